// File: hdl/erdi_pkg.sv
// constants, register map and carrier types for the receive defect interrupt block
// How it works
// - out-of-frame change interrupt fires on both declaration and clearance when enabled.
// - out-of-frame declared after framing bit errors in four consecutive frames.
// - out-of-frame cleared when framer enters in-frame from verify or out-of-frame.
// - out-of-frame interrupt enable is bit 3 of enable register 0x12.
// - enable bit one allows its interrupt, zero suppresses it.
// - any enabled defect-change interrupt drives the request output low.
// - out-of-frame change sets bit 3 of the interrupt status register.
// - status register 0x14 bits 4..0 clear on read, bits 7..5 read zero.
// - live out-of-frame state readable at bit 5 of register 0x11.
// - no automatic far-end failure insertion or removal in response to defects.
// - frame-loss change interrupt fires on declaration and clearance when enabled.
// - frame loss declared when out-of-frame persists beyond 1 ms or 3 ms.
// - frame loss cleared when framer returns to in-frame.
// - frame-loss interrupt enable is bit 2 of the enable register.
// - frame-loss change sets status flag, placed at bit 2 of status register.
// - alarm-indication change interrupt fires on declaration and clearance when enabled.
// - enable register holds read-write enables at bits 4..0, bits 7..5 read-only.
// - register 0x11 has timing select at bit 7 and live flags bits 6..0.
// - receive interrupts reach request only while bit 7 of register 0x04 is one.
// - internal detection declares signal loss after 32 consecutive zeros on both rails.
// - alarm indication declared when 7 or fewer zeros in 2 consecutive frames.
// - alarm indication cleared when 2 consecutive frames each carry 8 or more zeros.
package erdi_pkg;

   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;

   // register offsets
   localparam logic [7:0] LINE_CFG_ADDR   = 8'h00;
   localparam logic [7:0] BLOCK_IEN_ADDR  = 8'h04;
   localparam logic [7:0] CFG_STATUS_ADDR = 8'h11;
   localparam logic [7:0] IRQ_ENABLE_ADDR = 8'h12;
   localparam logic [7:0] IRQ_STATUS_ADDR = 8'h14;

   // field positions
   localparam int unsigned INT_LOS_EN_BIT   = 5;
   localparam int unsigned BLOCK_RX_EN_BIT  = 7;
   localparam int unsigned LOF_SEL_BIT      = 7;
   localparam int unsigned LIVE_LOF_BIT     = 6;
   localparam int unsigned LIVE_OOF_BIT     = 5;
   localparam int unsigned LIVE_LOS_BIT     = 4;
   localparam int unsigned LIVE_AIS_BIT     = 3;
   localparam int unsigned LIVE_UNSTAB_BIT  = 2;
   localparam int unsigned LIVE_TMARK_BIT   = 1;
   localparam int unsigned LIVE_FERF_BIT    = 0;
   localparam int unsigned EV_ALIGN_BIT     = 4;
   localparam int unsigned EV_OOF_BIT       = 3;
   localparam int unsigned EV_LOF_BIT       = 2;
   localparam int unsigned EV_LOS_BIT       = 1;
   localparam int unsigned EV_AIS_BIT       = 0;
   localparam int unsigned EV_N             = 5;

   // reset values
   localparam logic [EV_N-1:0] EV_RESET = 5'h00;
   localparam logic            BIT_RESET = 1'b0;

   // defect thresholds
   localparam int unsigned OOF_FRAMES       = 4;
   localparam int unsigned LOS_ZERO_RUN     = 32;
   localparam int unsigned LOS_CLEAR_BITS   = 32;
   localparam int unsigned LOS_CLEAR_ZEROS  = 4;
   localparam int unsigned AIS_DECLARE_MAX  = 7;
   localparam int unsigned AIS_CLEAR_MIN    = 8;

   // timing
   localparam int unsigned CLK_PERIOD_PS    = 8000;
   localparam int unsigned LOF_SHORT_MS     = 1;
   localparam int unsigned LOF_LONG_MS      = 3;
   localparam int unsigned LOF_SHORT_CYCLES = LOF_SHORT_MS * 1000000000 / CLK_PERIOD_PS;
   localparam int unsigned LOF_LONG_CYCLES  = LOF_LONG_MS * 1000000000 / CLK_PERIOD_PS;

   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } erdi_bus_req_t;

   typedef struct packed {
      logic bit_valid;
      logic pos_rail;
      logic neg_rail;
   } erdi_line_t;

   typedef struct packed {
      logic frame_end;
      logic fas_error;
      logic in_frame;
      logic alignment_change;
   } erdi_framer_t;

endpackage : erdi_pkg

// File: hdl/erdi_top.sv
// receive defect tracking, change flags and interrupt request
//
// Design decision made here: strobed register access.
`timescale 1ns/100ps
module erdi_top #(
   parameter int unsigned LOF_SHORT_CYCLES = erdi_pkg::LOF_SHORT_CYCLES,
   parameter int unsigned LOF_LONG_CYCLES  = erdi_pkg::LOF_LONG_CYCLES
) (
   input  wire logic                 clk_i,
   input  wire logic                 arst_n_i,
   input  wire erdi_pkg::erdi_bus_req_t bus_i,
   output logic [erdi_pkg::DATA_W-1:0] rd_data_o,
   input  wire erdi_pkg::erdi_line_t   line_i,
   input  wire erdi_pkg::erdi_framer_t framer_i,
   input  wire logic                 ext_signal_loss_i,
   input  wire logic                 payload_unstable_flag_i,
   input  wire logic                 trail_mark_flag_i,
   input  wire logic                 rx_far_end_failure_state_i,
   output logic                      int_n_o,
   output logic                      rx_out_of_frame_state_o,
   output logic                      rx_frame_loss_state_o,
   output logic                      rx_signal_loss_state_o,
   output logic                      rx_alarm_indication_state_o
);

   localparam int unsigned TMR_W = $clog2(LOF_LONG_CYCLES + 1);

   ////////////////////////////////////////////////////////////////////////////
   // register state

   logic                      internal_signal_loss_detect_reg;
   logic                      block_rx_en_reg;
   logic                      frame_loss_timing_select_reg;
   logic [erdi_pkg::EV_N-1:0] ien_reg;
   logic [erdi_pkg::EV_N-1:0] ists_reg;
   logic [erdi_pkg::EV_N-1:0] ists_next;
   logic [erdi_pkg::EV_N-1:0] event_next;

   // defect states
   logic                      oof_reg;
   logic                      lof_reg;
   logic                      int_los_reg;
   logic                      ais_reg;
   logic                      los_live;

   logic                      oof_prev_reg;
   logic                      lof_prev_reg;
   logic                      los_prev_reg;
   logic                      ais_prev_reg;
   logic                      in_frame_prev_reg;
   logic                      in_frame_entry;

   logic [2:0]                fas_run_reg;
   logic [TMR_W-1:0]          lof_tmr_reg;
   logic [TMR_W-1:0]          lof_limit;
   logic [5:0]                zero_run_reg;
   logic [5:0]                clean_bits_reg;
   logic [3:0]                zeros_cur_reg;
   logic [3:0]                zeros_prev_reg;
   logic                      prev_valid_reg;
   logic                      line_zero;
   logic [4:0]                zeros_pair;
   logic [3:0]                zeros_frame;

   logic [erdi_pkg::DATA_W-1:0] cfg_status_view;
   logic                        rd_status;

   ////////////////////////////////////////////////////////////////////////////
   // register writes

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         internal_signal_loss_detect_reg <= erdi_pkg::BIT_RESET;
         block_rx_en_reg                 <= erdi_pkg::BIT_RESET;
         frame_loss_timing_select_reg    <= erdi_pkg::BIT_RESET;
         ien_reg                         <= erdi_pkg::EV_RESET;
      end else if (bus_i.wr) begin
         unique case (bus_i.addr)
            erdi_pkg::LINE_CFG_ADDR: begin
               internal_signal_loss_detect_reg <= bus_i.wdata[erdi_pkg::INT_LOS_EN_BIT];
            end
            erdi_pkg::BLOCK_IEN_ADDR: begin
               block_rx_en_reg <= bus_i.wdata[erdi_pkg::BLOCK_RX_EN_BIT];
            end
            erdi_pkg::CFG_STATUS_ADDR: begin
               // only the timing select is writable here
               frame_loss_timing_select_reg <= bus_i.wdata[erdi_pkg::LOF_SEL_BIT];
            end
            erdi_pkg::IRQ_ENABLE_ADDR: begin
               ien_reg <= bus_i.wdata[erdi_pkg::EV_N-1:0];
            end
            default: begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // out-of-frame

   assign in_frame_entry = framer_i.in_frame && !in_frame_prev_reg;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         in_frame_prev_reg <= 1'b0;
      end else begin
         in_frame_prev_reg <= framer_i.in_frame;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         fas_run_reg <= 3'h0;
         oof_reg     <= 1'b0;
      end else begin
         if (in_frame_entry) begin
            fas_run_reg <= 3'h0;
            oof_reg     <= 1'b0;
         end else if (framer_i.frame_end) begin
            if (!framer_i.fas_error) begin
               fas_run_reg <= 3'h0;
            end else if (fas_run_reg == 3'(erdi_pkg::OOF_FRAMES - 1)) begin
               fas_run_reg <= 3'h0;
               oof_reg     <= 1'b1;
            end else begin
               fas_run_reg <= fas_run_reg + 3'h1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // frame loss: timer runs while out-of-frame persists

   // select zero gives the short period
   assign lof_limit = frame_loss_timing_select_reg ? TMR_W'(LOF_LONG_CYCLES)
                                                   : TMR_W'(LOF_SHORT_CYCLES);

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         lof_tmr_reg <= '0;
         lof_reg     <= 1'b0;
      end else begin
         if (in_frame_entry) begin
            lof_tmr_reg <= '0;
            lof_reg     <= 1'b0;
         end else if (oof_reg && !lof_reg) begin
            if (lof_tmr_reg >= lof_limit - TMR_W'(1)) begin
               lof_reg <= 1'b1;
            end else begin
               lof_tmr_reg <= lof_tmr_reg + TMR_W'(1);
            end
         end else if (!oof_reg) begin
            lof_tmr_reg <= '0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // signal loss from rails

   assign line_zero = !line_i.pos_rail && !line_i.neg_rail;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         zero_run_reg   <= 6'h00;
         clean_bits_reg <= 6'h00;
         int_los_reg    <= 1'b0;
      end else if (!internal_signal_loss_detect_reg) begin
         zero_run_reg   <= 6'h00;
         clean_bits_reg <= 6'h00;
         int_los_reg    <= 1'b0;
      end else if (line_i.bit_valid) begin
         if (line_zero) begin
            if (zero_run_reg != 6'(erdi_pkg::LOS_ZERO_RUN)) begin
               zero_run_reg <= zero_run_reg + 6'h01;
            end
            if (zero_run_reg == 6'(erdi_pkg::LOS_ZERO_RUN - 1)) begin
               int_los_reg <= 1'b1;
            end
         end else begin
            zero_run_reg <= 6'h00;
         end
         // a run of four zeros restarts the clean window
         if (line_zero && zero_run_reg >= 6'(erdi_pkg::LOS_CLEAR_ZEROS - 1)) begin
            clean_bits_reg <= 6'h00;
         end else if (clean_bits_reg == 6'(erdi_pkg::LOS_CLEAR_BITS - 1)) begin
            clean_bits_reg <= 6'h00;
            int_los_reg    <= 1'b0;
         end else begin
            clean_bits_reg <= clean_bits_reg + 6'h01;
         end
      end
   end

   assign los_live = ext_signal_loss_i || int_los_reg;

   ////////////////////////////////////////////////////////////////////////////
   // alarm indication: zero density over two frames

   assign zeros_frame = (line_i.bit_valid && line_zero
                         && zeros_cur_reg != 4'(erdi_pkg::AIS_CLEAR_MIN))
                        ? zeros_cur_reg + 4'h1 : zeros_cur_reg;
   assign zeros_pair  = {1'b0, zeros_prev_reg} + {1'b0, zeros_frame};

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         zeros_cur_reg  <= 4'h0;
         zeros_prev_reg <= 4'h0;
         prev_valid_reg <= 1'b0;
         ais_reg        <= 1'b0;
      end else if (framer_i.frame_end) begin
         zeros_cur_reg  <= 4'h0;
         zeros_prev_reg <= zeros_frame;
         prev_valid_reg <= 1'b1;
         if (prev_valid_reg) begin
            if (zeros_pair <= 5'(erdi_pkg::AIS_DECLARE_MAX)) begin
               ais_reg <= 1'b1;
            end else if (zeros_prev_reg >= 4'(erdi_pkg::AIS_CLEAR_MIN)
                         && zeros_frame >= 4'(erdi_pkg::AIS_CLEAR_MIN)) begin
               ais_reg <= 1'b0;
            end
         end
      end else begin
         zeros_cur_reg <= zeros_frame;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // change detection and sticky status

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         oof_prev_reg <= 1'b0;
         lof_prev_reg <= 1'b0;
         los_prev_reg <= 1'b0;
         ais_prev_reg <= 1'b0;
      end else begin
         oof_prev_reg <= oof_reg;
         lof_prev_reg <= lof_reg;
         los_prev_reg <= los_live;
         ais_prev_reg <= ais_reg;
      end
   end

   always_comb begin
      event_next = '0;
      event_next[erdi_pkg::EV_ALIGN_BIT] = framer_i.alignment_change;
      event_next[erdi_pkg::EV_OOF_BIT]   = oof_reg != oof_prev_reg;
      event_next[erdi_pkg::EV_LOF_BIT]   = lof_reg != lof_prev_reg;
      event_next[erdi_pkg::EV_LOS_BIT]   = los_live != los_prev_reg;
      event_next[erdi_pkg::EV_AIS_BIT]   = ais_reg != ais_prev_reg;
   end

   assign rd_status = bus_i.rd && bus_i.addr == erdi_pkg::IRQ_STATUS_ADDR;

   // a new change in the read cycle survives the clear
   always_comb begin
      ists_next = rd_status ? erdi_pkg::EV_RESET : ists_reg;
      // suppressed sources do not latch
      ists_next = ists_next | (event_next & ien_reg);
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ists_reg <= erdi_pkg::EV_RESET;
      end else begin
         ists_reg <= ists_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt request: held low while bit 7 of 0x04 is one until every enabled flag is read away

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         int_n_o <= 1'b1;
      end else begin
         int_n_o <= !(block_rx_en_reg && |(ists_next & ien_reg));
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read port

   always_comb begin
      cfg_status_view = '0;
      cfg_status_view[erdi_pkg::LOF_SEL_BIT]     = frame_loss_timing_select_reg;
      cfg_status_view[erdi_pkg::LIVE_LOF_BIT]    = lof_reg;
      cfg_status_view[erdi_pkg::LIVE_OOF_BIT]    = oof_reg;
      cfg_status_view[erdi_pkg::LIVE_LOS_BIT]    = los_live;
      cfg_status_view[erdi_pkg::LIVE_AIS_BIT]    = ais_reg;
      cfg_status_view[erdi_pkg::LIVE_UNSTAB_BIT] = payload_unstable_flag_i;
      cfg_status_view[erdi_pkg::LIVE_TMARK_BIT]  = trail_mark_flag_i;
      // far-end failure is only reported; its transmission is left to software
      cfg_status_view[erdi_pkg::LIVE_FERF_BIT]   = rx_far_end_failure_state_i;
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rd_data_o <= '0;
      end else if (bus_i.rd) begin
         unique case (bus_i.addr)
            erdi_pkg::LINE_CFG_ADDR: begin
               rd_data_o <= 8'(internal_signal_loss_detect_reg) << erdi_pkg::INT_LOS_EN_BIT;
            end
            erdi_pkg::BLOCK_IEN_ADDR: begin
               rd_data_o <= 8'(block_rx_en_reg) << erdi_pkg::BLOCK_RX_EN_BIT;
            end
            erdi_pkg::CFG_STATUS_ADDR: begin
               rd_data_o <= cfg_status_view;
            end
            erdi_pkg::IRQ_ENABLE_ADDR: begin
               rd_data_o <= {3'h0, ien_reg};
            end
            erdi_pkg::IRQ_STATUS_ADDR: begin
               rd_data_o <= {3'h0, ists_reg};
            end
            default: begin
               rd_data_o <= '0;
            end
         endcase
      end else begin
         rd_data_o <= '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // live defect outputs; software drives far-end failure from bits 5 and 4 of register 0x11

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rx_out_of_frame_state_o     <= 1'b0;
         rx_frame_loss_state_o       <= 1'b0;
         rx_signal_loss_state_o      <= 1'b0;
         rx_alarm_indication_state_o <= 1'b0;
      end else begin
         rx_out_of_frame_state_o     <= oof_reg;
         rx_frame_loss_state_o       <= lof_reg;
         rx_signal_loss_state_o      <= los_live;
         rx_alarm_indication_state_o <= ais_reg;
      end
   end

endmodule : erdi_top

// File: dv/erdi_monitor.sv
// assertion checker for the receive defect interrupt block
`timescale 1ns/100ps
module erdi_monitor #(
   parameter int unsigned LOF_SHORT_CYCLES = 20,
   parameter int unsigned LOF_LONG_CYCLES  = 60
) (
   input wire logic                         clk_i,
   input wire logic                         arst_n_i,
   input wire erdi_pkg::erdi_bus_req_t      bus_i,
   input wire logic [erdi_pkg::DATA_W-1:0]  rd_data_o,
   input wire erdi_pkg::erdi_framer_t       framer_i,
   input wire logic                         int_n_o,
   input wire logic                         rx_out_of_frame_state_o,
   input wire logic                         rx_frame_loss_state_o
);
   logic [4:0]  ien_reg;
   logic        blk_reg;
   logic        sel_reg;
   logic [1:0]  err_reg;
   logic [31:0] run_reg;
   logic [31:0] lof_n;
   assign lof_n = sel_reg ? LOF_LONG_CYCLES : LOF_SHORT_CYCLES;
   ////////////////////////////////////////////////////////////////////////
   // shadow of the software-written controls
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ien_reg <= 5'h00;
         blk_reg <= 1'b0;
         sel_reg <= 1'b0;
      end else if (bus_i.wr) begin
         if (bus_i.addr == 8'h12) ien_reg <= bus_i.wdata[4:0];
         if (bus_i.addr == 8'h04) blk_reg <= bus_i.wdata[7];
         if (bus_i.addr == 8'h11) sel_reg <= bus_i.wdata[7];
      end
   end
   // errored-frame run as the framer keeps it
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         err_reg <= 2'h0;
         run_reg <= 32'h0;
      end else begin
         if ($rose(framer_i.in_frame)) err_reg <= 2'h0;
         else if (framer_i.frame_end) err_reg <= framer_i.fas_error ? err_reg + 2'h1 : 2'h0;
         run_reg <= rx_out_of_frame_state_o ? run_reg + 32'h1 : 32'h0;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   rd_idle_a: assert property (!$past(bus_i.rd) |-> rd_data_o == 8'h00)
      else $error("read data not zero outside a read");
   sts_unused_a: assert property ($past(bus_i.rd) && $past(bus_i.addr) == 8'h14 |-> rd_data_o[7:5] == 3'h0)
      else $error("status unused bits not zero");
   ien_readback_a: assert property ($past(bus_i.rd) && $past(bus_i.addr) == 8'h12 |-> rd_data_o == {3'h0, ien_reg})
      else $error("enable register readback wrong");
   live_oof_a: assert property ($past(bus_i.rd) && $past(bus_i.addr) == 8'h11 |-> rd_data_o[5] == rx_out_of_frame_state_o)
      else $error("live out-of-frame bit wrong");
   live_lof_a: assert property ($past(bus_i.rd) && $past(bus_i.addr) == 8'h11 |-> rd_data_o[6] == rx_frame_loss_state_o && rd_data_o[7] == sel_reg)
      else $error("live frame-loss or select bit wrong");
   oof_irq_a: assert property ($rose(rx_out_of_frame_state_o) && ien_reg[3] && blk_reg |-> !int_n_o)
      else $error("out-of-frame change gave no request");
   blk_gate_a: assert property (!blk_reg && !$past(blk_reg) |-> int_n_o)
      else $error("request while block disabled");
   oof_decl_a: assert property (framer_i.frame_end && framer_i.fas_error && err_reg == 2'h3 |-> ##[1:3] rx_out_of_frame_state_o)
      else $error("out-of-frame not declared on fourth errored frame");
   infrm_clr_a: assert property ($rose(framer_i.in_frame) |-> ##[1:3] !rx_out_of_frame_state_o && !rx_frame_loss_state_o)
      else $error("defects not cleared on in-frame entry");
   lof_time_a: assert property ($rose(rx_frame_loss_state_o) |-> run_reg + 3 >= lof_n && run_reg <= lof_n + 3)
      else $error("frame loss declared at wrong time");
   cover property ($rose(rx_frame_loss_state_o));
   cover property ($fell(int_n_o));
   cover property ($rose(framer_i.in_frame));
endmodule : erdi_monitor

bind erdi_top erdi_monitor #(
   .LOF_SHORT_CYCLES(LOF_SHORT_CYCLES),
   .LOF_LONG_CYCLES (LOF_LONG_CYCLES)
) u_erdi_monitor (
   .clk_i                  (clk_i),
   .arst_n_i               (arst_n_i),
   .bus_i                  (bus_i),
   .rd_data_o              (rd_data_o),
   .framer_i               (framer_i),
   .int_n_o                (int_n_o),
   .rx_out_of_frame_state_o(rx_out_of_frame_state_o),
   .rx_frame_loss_state_o  (rx_frame_loss_state_o)
);

// File: dv/erdi_host_model.sv
// software model: register access and far-end failure servicing
`timescale 1ns/100ps
module erdi_host_model (
   input  wire logic                        clk_i,
   input  wire logic [erdi_pkg::DATA_W-1:0] rd_data_i,
   output erdi_pkg::erdi_bus_req_t          bus_o,
   output logic                             ferf_o
);
   initial begin
      bus_o = '0;
      ferf_o = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      bus_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk_i);
      bus_o.wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      bus_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk_i);
      bus_o.rd <= 1'b0;
      #1;
      d = rd_data_i;
      // device never does this itself, so software follows the out-of-frame and signal-loss live flags
      if (a == 8'h11) ferf_o <= d[5] | d[4];
   endtask : rd
endmodule : erdi_host_model

// File: dv/erdi_tb_top.sv
// testbench for the receive defect interrupt block
`timescale 1ns/100ps
module erdi_tb_top;
   logic                    clk_i;
   logic                    arst_n_i;
   erdi_pkg::erdi_bus_req_t bus;
   logic [7:0]              rd_data;
   erdi_pkg::erdi_line_t    line_i;
   erdi_pkg::erdi_framer_t  framer_i;
   logic                    ext_los;
   logic                    int_n;
   logic                    ferf;
   logic [3:0]              st;
   integer                  seed;
   integer                  error_cnt;
   integer                  n_checks;
   integer                  cyc;
   logic [7:0]              d;

   erdi_top #(.LOF_SHORT_CYCLES(20), .LOF_LONG_CYCLES(60)) u_erdi_top (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .bus_i(bus), .rd_data_o(rd_data), .line_i(line_i),
      .framer_i(framer_i), .ext_signal_loss_i(ext_los), .payload_unstable_flag_i(ext_los),
      .trail_mark_flag_i(ext_los), .rx_far_end_failure_state_i(ferf), .int_n_o(int_n),
      .rx_out_of_frame_state_o(st[3]), .rx_frame_loss_state_o(st[2]),
      .rx_signal_loss_state_o(st[1]), .rx_alarm_indication_state_o(st[0]));
   erdi_host_model u_erdi_host_model (.clk_i(clk_i), .rd_data_i(rd_data), .bus_o(bus), .ferf_o(ferf));

   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cyc = cyc + 1;
      if (cyc == 6000) begin
         error_cnt = error_cnt + 1;
         final_report();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] cfg_exp(input logic s, input logic [3:0] v, input logic f);
      return {s, v, 2'b00, f};
   endfunction : cfg_exp
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      n_checks = n_checks + 1;
      if (got !== exp) begin
         error_cnt = error_cnt + 1;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk8
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] v;
      u_erdi_host_model.rd(a, v);
      chk8(v, exp);
   endtask : rchk
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      u_erdi_host_model.wr(a, v);
   endtask : wr
   // sixteen line bits, the first nz of them zero, then a frame boundary
   task automatic frame(input logic err, input int nz);
      logic b;
      for (int i = 0; i < 16; i++) begin
         b = $random(seed);
         @(posedge clk_i) line_i <= (i < nz) ? 3'b100 : {1'b1, b, ~b};
      end
      @(posedge clk_i) line_i <= 3'b000;
      framer_i.frame_end <= 1'b1;
      framer_i.fas_error <= err;
      @(posedge clk_i) framer_i.frame_end <= 1'b0;
   endtask : frame
   task automatic wait_n(input int n);
      repeat (n) @(posedge clk_i);
   endtask : wait_n
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : final_report
   ////////////////////////////////////////////////////////////////////////
   initial begin
      seed = 23; error_cnt = 0; n_checks = 0; cyc = 0; ext_los = 1'b0;
      line_i = '0; framer_i = 4'b0010; arst_n_i = 1'b0;
      wait_n(5);
      arst_n_i <= 1'b1;
      rchk(8'h11, 8'h00); rchk(8'h12, 8'h00); rchk(8'h14, 8'h00);
      repeat (8) begin
         d = $random(seed);
         wr(8'h12, d); rchk(8'h12, {3'h0, d[4:0]});
      end
      wr(8'h11, 8'hff); rchk(8'h11, 8'h80);
      wr(8'h04, 8'hff); rchk(8'h04, 8'h80);
      wr(8'h33, 8'hff); rchk(8'h33, 8'h00);
      $display("test registers done");
      // out-of-frame then frame loss with the short period
      wr(8'h11, 8'h00); wr(8'h12, 8'h0c);
      @(posedge clk_i) framer_i.in_frame <= 1'b0;
      repeat (4) frame(1'b1, 8);
      wait_n(3);
      chk8({7'h0, int_n}, 8'h00);
      rchk(8'h11, cfg_exp(1'b0, 4'b0100, ferf));
      rchk(8'h14, 8'h08);
      wait_n(1); #1;
      chk8({7'h0, int_n}, 8'h01);
      wait_n(25);
      rchk(8'h14, 8'h04);
      rchk(8'h11, cfg_exp(1'b0, 4'b1100, ferf));
      @(posedge clk_i) framer_i.in_frame <= 1'b1;
      wait_n(4);
      rchk(8'h14, 8'h0c);
      $display("test short frame loss done");
      wr(8'h11, 8'h80);
      @(posedge clk_i) framer_i.in_frame <= 1'b0;
      repeat (4) frame(1'b1, 8);
      wait_n(40);
      rchk(8'h11, cfg_exp(1'b1, 4'b0100, ferf));
      wait_n(30);
      rchk(8'h11, cfg_exp(1'b1, 4'b1100, ferf));
      @(posedge clk_i) framer_i.in_frame <= 1'b1;
      wait_n(4);
      rchk(8'h14, 8'h0c);
      $display("test long frame loss done");
      // masked source, then masked block
      wr(8'h12, 8'h00);
      @(posedge clk_i) framer_i.in_frame <= 1'b0;
      repeat (4) frame(1'b1, 8);
      wait_n(3);
      chk8({7'h0, int_n}, 8'h01);
      rchk(8'h14, 8'h00);
      wr(8'h12, 8'h08); wr(8'h04, 8'h00);
      @(posedge clk_i) framer_i.in_frame <= 1'b1;
      wait_n(4);
      chk8({7'h0, int_n}, 8'h01);
      rchk(8'h14, 8'h08);
      wr(8'h04, 8'h80);
      $display("test masking done");
      // alarm indication at both zero-count boundaries
      wr(8'h12, 8'h01);
      frame(1'b0, 7); frame(1'b0, 0);
      wait_n(3);
      rchk(8'h14, 8'h01);
      frame(1'b0, 8);
      wait_n(3);
      rchk(8'h11, cfg_exp(1'b1, 4'b0001, ferf));
      chk8({4'h0, st}, 8'h01);
      frame(1'b0, 8);
      wait_n(3);
      rchk(8'h14, 8'h01);
      $display("test alarm indication done");
      // signal loss: internal zero run, random recovery, external input
      wr(8'h00, 8'h20); wr(8'h12, 8'h02);
      repeat (32) @(posedge clk_i) line_i <= 3'b100;
      @(posedge clk_i) line_i <= 3'b000;
      wait_n(3);
      rchk(8'h11, cfg_exp(1'b1, 4'b0010, ferf));
      chk8({4'h0, st}, 8'h02);
      rchk(8'h14, 8'h02);
      repeat (40) begin
         d = $random(seed);
         @(posedge clk_i) line_i <= {1'b1, d[0], ~d[0]};
      end
      wait_n(3);
      rchk(8'h14, 8'h02);
      @(posedge clk_i) ext_los <= 1'b1;
      wait_n(3);
      rchk(8'h11, cfg_exp(1'b1, 4'b0010, ferf) | 8'h06);
      @(posedge clk_i) ext_los <= 1'b0;
      wr(8'h12, 8'h10);
      @(posedge clk_i) framer_i.alignment_change <= 1'b1;
      @(posedge clk_i) framer_i.alignment_change <= 1'b0;
      wait_n(3);
      rchk(8'h14, 8'h12);
      $display("test signal loss and alignment done");
      final_report();
   end
endmodule : erdi_tb_top
